/* rci_pkg.sv */
// Package for the reset cause and initial state block
// Assumes a single 200 MHz core clock; the named constants used by the other files live here
package rci_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] RCI_CAUSE_ADDR = 16'hffac;
  localparam logic [15:0] RCI_LVCTL_ADDR = 16'hff78;
  localparam logic [7:0] RCI_CAUSE_RST = 8'h00;
  localparam int RCI_WDT_BIT = 4;
  localparam int RCI_LVD_BIT = 0;
  localparam int RCI_LV_EN_BIT = 7;
  localparam int RCI_LV_MD_BIT = 1;
  localparam int RCI_LV_FLAG_BIT = 0;
  localparam logic [7:0] RCI_LV_WMASK = 8'h82;

  // ----------------------------------------
  // Initial values of peripheral state
  // ----------------------------------------
  localparam logic [15:0] RCI_ZERO16 = 16'h0000;
  localparam logic [7:0] RCI_ZERO8 = 8'h00;
  localparam logic [7:0] RCI_ONES8 = 8'hff;
  localparam logic [7:0] RCI_MASK1H_INIT = 8'hdf;
  localparam logic [7:0] RCI_ASYNC_MODE_INIT = 8'h01;
  localparam logic [7:0] RCI_ASYNC_BAUD_INIT = 8'h1f;
  localparam logic [7:0] RCI_FLASH_PROG_MODE_CTRL_USER = 8'h08;
  localparam logic [7:0] RCI_FLASH_PROG_MODE_CTRL_OBP = 8'h0c;

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  typedef enum logic [3:0] {
    RCI_SRC_NONE = 4'h0,
    RCI_SRC_PIN = 4'h1,
    RCI_SRC_POC = 4'h2,
    RCI_SRC_WDT = 4'h4,
    RCI_SRC_LVD = 4'h8
  } rci_src_t;

  // Processor read/write port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rci_bus_t;

  // Initial state handed to the peripherals on a reset
  typedef struct packed {
    logic [15:0] wide_timer_count;
    logic [15:0] wide_capcmp_a;
    logic [15:0] wide_capcmp_b;
    logic [7:0] wide_timer_mode;
    logic [7:0] wide_timer_prescale;
    logic [7:0] wide_capture_ctrl;
    logic [7:0] wide_timer_out_ctrl;
    logic [7:0] byte_timer_regs;
    logic [7:0] htimer_regs;
    logic [7:0] clock_out_select;
    logic [7:0] async_mode;
    logic [7:0] async_baud_ctrl;
    logic [7:0] async_rx_buffer;
    logic [7:0] async_tx_shift;
    logic [7:0] sync_regs;
    logic [7:0] converter_regs;
    logic [15:0] muldiv_words;
    logic [7:0] muldiv_control;
    logic [7:0] rt_output_regs;
    logic [7:0] irq_request_flags;
    logic [7:0] irq_priority_flags;
    logic [7:0] irq_mask_flags;
    logic [7:0] irq_mask_high_second;
    logic [7:0] ext_irq_edge_enable;
    logic [7:0] flash_status_reg;
    logic [7:0] flash_prog_mode_ctrl;
  } rci_init_t;

endpackage : rci_pkg

/* rci_init_table.sv */
// Fixed table of peripheral initial values loaded on reset acknowledge
// Assumes the on-board programming strap is stable while a reset is in progress
module rci_init_table
  import rci_pkg::*;
(
  // Mode
  input wire logic i_obp_mode,
  // Table
  output rci_init_t o_init
);

  // ----------------------------------------
  // Constant assignments
  // ----------------------------------------
  // Registers left undefined (converter result, sync tx buffer,
  // flash protect command) are simply not driven by this table
  always_comb begin
    o_init = '0;
    o_init.wide_timer_count = RCI_ZERO16;
    o_init.wide_capcmp_a = RCI_ZERO16;
    o_init.wide_capcmp_b = RCI_ZERO16;
    o_init.wide_timer_mode = RCI_ZERO8;
    o_init.wide_timer_prescale = RCI_ZERO8;
    o_init.wide_capture_ctrl = RCI_ZERO8;
    o_init.wide_timer_out_ctrl = RCI_ZERO8;
    o_init.byte_timer_regs = RCI_ZERO8;
    o_init.htimer_regs = RCI_ZERO8;
    o_init.clock_out_select = RCI_ZERO8;
    o_init.async_mode = RCI_ASYNC_MODE_INIT;
    o_init.async_baud_ctrl = RCI_ASYNC_BAUD_INIT;
    o_init.async_rx_buffer = RCI_ONES8;
    o_init.async_tx_shift = RCI_ONES8;
    o_init.sync_regs = RCI_ZERO8;
    o_init.converter_regs = RCI_ZERO8;
    o_init.muldiv_words = RCI_ZERO16;
    o_init.muldiv_control = RCI_ZERO8;
    o_init.rt_output_regs = RCI_ZERO8;
    o_init.irq_request_flags = RCI_ZERO8;
    o_init.irq_priority_flags = RCI_ONES8;
    o_init.irq_mask_flags = RCI_ONES8;
    o_init.irq_mask_high_second = RCI_MASK1H_INIT;
    o_init.ext_irq_edge_enable = RCI_ZERO8;
    o_init.flash_status_reg = RCI_ZERO8;
    o_init.flash_prog_mode_ctrl = i_obp_mode ? RCI_FLASH_PROG_MODE_CTRL_OBP : RCI_FLASH_PROG_MODE_CTRL_USER;
  end

endmodule : rci_init_table

/* rci_reset_cause.sv */
// Reset cause recorder, low-voltage control register and initial state loader
// Assumes reset requests are synchronous one-cycle-or-longer levels from on-chip sources;
// the core clock keeps running through an internal reset so the cause can be latched.
//
// What this block does
// - Pin, power-on, or read clears cause
// - Watchdog reset request sets bit four
// - Low-voltage reset request sets bit zero
// - Watchdog or low-voltage reset keeps other flag
// - Power-on-clear raises internal reset at power-up
// - Only program counter undefined during reset
// - Standby reset keeps memory; table still reloads
// - Wide timer registers initialise to zero
// - Byte timers, H timer, clock select zero
// - Async serial: mode 01, baud 1F, buffers FF
// - Sync serial registers zero, buffer undefined
// - Converter result undefined, controls zero
// - Multiplier divider registers initialise to zero
// - Real-time output registers initialise to zero
// - Irq requests zero, priority/mask FF, one DF
// - External edge enables initialise to zero
// - Flash command undefined, status zero
// - Flash mode control 08 user, 0C board
// - Low-voltage control resets per source
// - Low-voltage enable bits survive own reset
module rci_reset_cause
  import rci_pkg::*;
(
  // Clock and power-on reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Reset requests
  input wire logic i_pin_reset,
  input wire logic i_wdt_reset,
  input wire logic i_lvd_reset,
  input wire logic i_lvd_compare,
  input wire logic i_standby,
  input wire logic i_obp_mode,
  // Processor port
  input wire rci_pkg::rci_bus_t i_bus,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // Reset outputs
  output logic o_sys_reset,
  output logic o_pc_undefined,
  output logic o_ram_hold,
  output logic o_lv_enable,
  output logic o_lv_reset_mode,
  output logic o_lv_irq,
  output rci_pkg::rci_init_t o_init
);
  import rci_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic wdt_flag_q;
  logic wdt_flag_d;
  logic lvd_flag_q;
  logic lvd_flag_d;
  logic lv_en_q;
  logic lv_en_d;
  logic lv_md_q;
  logic lv_md_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic sys_reset_q;
  logic standby_q;
  logic lv_irq_q;
  rci_init_t init_q;
  rci_init_t init_d;
  rci_src_t src;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Pin has priority over internal sources; a pin reset clears all history
  wire cause_hit = (i_bus.addr == RCI_CAUSE_ADDR);
  wire lvctl_hit = (i_bus.addr == RCI_LVCTL_ADDR);
  wire cause_rd = i_bus.rd && cause_hit;
  wire lvctl_wr = i_bus.wr && lvctl_hit;
  wire any_reset = i_pin_reset || i_wdt_reset || (i_lvd_reset && lv_md_q && lv_en_q);
  wire lvd_act = i_lvd_reset && lv_md_q && lv_en_q;
  wire [7:0] cause_val = cause_byte(wdt_flag_q, lvd_flag_q);
  wire [7:0] lvctl_val = {lv_en_q, 5'b0_0000, lv_md_q, i_lvd_compare && lv_en_q};

  assign src = i_pin_reset ? RCI_SRC_PIN :
               i_wdt_reset ? RCI_SRC_WDT :
               lvd_act ? RCI_SRC_LVD : RCI_SRC_NONE;

  // Unused bit positions are tied to zero here
  function automatic logic [7:0] cause_byte(input logic wdt, input logic lvd);
    logic [7:0] v;
    v = RCI_CAUSE_RST;
    v[RCI_WDT_BIT] = wdt;
    v[RCI_LVD_BIT] = lvd;
    return v;
  endfunction : cause_byte

  // ----------------------------------------
  // Cause flags
  // ----------------------------------------
  // A reset request that lands on the read cycle wins, so no cause is lost
  always_comb begin
    wdt_flag_d = cause_rd ? 1'b0 : wdt_flag_q;
    lvd_flag_d = cause_rd ? 1'b0 : lvd_flag_q;
    case (src)
      RCI_SRC_PIN: begin
        wdt_flag_d = 1'b0;
        lvd_flag_d = 1'b0;
      end
      RCI_SRC_WDT: begin
        wdt_flag_d = 1'b1;
        if (lvd_act) begin
          lvd_flag_d = 1'b1;
        end
      end
      RCI_SRC_LVD: begin
        lvd_flag_d = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------
  // Low-voltage control
  // ----------------------------------------
  // The detector's own reset must not disable itself, else it would loop off
  always_comb begin
    lv_en_d = lv_en_q;
    lv_md_d = lv_md_q;
    if (i_pin_reset || i_wdt_reset) begin
      lv_en_d = 1'b0;
      lv_md_d = 1'b0;
    end else if (lvd_act) begin
      lv_en_d = lv_en_q;
      lv_md_d = lv_md_q;
    end else if (lvctl_wr) begin
      lv_en_d = i_bus.wdata[RCI_LV_EN_BIT] & RCI_LV_WMASK[RCI_LV_EN_BIT];
      lv_md_d = i_bus.wdata[RCI_LV_MD_BIT] & RCI_LV_WMASK[RCI_LV_MD_BIT];
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Cause register is read-only; writes to it fall through untouched
  always_comb begin
    rdata_d = RCI_ZERO8;
    if (cause_rd) begin
      rdata_d = cause_val;
    end else if (i_bus.rd && lvctl_hit) begin
      rdata_d = lvctl_val;
    end
  end

  // ----------------------------------------
  // Initial state
  // ----------------------------------------
  // Reloaded on every reset; held otherwise so peripherals see stable values
  rci_init_table u_table (
    .i_obp_mode(i_obp_mode),
    .o_init(init_d)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Async reset is the power-on-clear; it clears everything but the system reset, which it sets
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wdt_flag_q <= 1'b0;
      lvd_flag_q <= 1'b0;
      lv_en_q <= 1'b0;
      lv_md_q <= 1'b0;
    end else begin
      wdt_flag_q <= wdt_flag_d;
      lvd_flag_q <= lvd_flag_d;
      lv_en_q <= lv_en_d;
      lv_md_q <= lv_md_d;
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= RCI_ZERO8;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= i_bus.rd && (cause_hit || lvctl_hit);
    end
  end

  // Power-on-clear drives the system reset from the start
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_reset_q <= 1'b1;
      standby_q <= 1'b0;
      lv_irq_q <= 1'b0;
    end else begin
      sys_reset_q <= any_reset;
      standby_q <= any_reset ? (standby_q || i_standby) : i_standby;
      lv_irq_q <= lv_en_q && !lv_md_q && i_lvd_compare;
    end
  end

  // Table reload; data memory is outside and kept when standby_q is high
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      init_q <= '0;
    end else if (any_reset || sys_reset_q) begin
      init_q <= init_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Only the program counter is flagged undefined while reset stands
  assign o_rdata = rdata_q;
  assign o_rdata_valid = rvalid_q;
  assign o_sys_reset = sys_reset_q;
  assign o_pc_undefined = sys_reset_q;
  assign o_ram_hold = standby_q;
  assign o_lv_enable = lv_en_q;
  assign o_lv_reset_mode = lv_md_q;
  assign o_lv_irq = lv_irq_q;
  assign o_init = init_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Power-on-clear holds the system reset for as long as it stands
  poc_reset_a: assert property (@(posedge i_core_clk)
    !i_rst_b |=> o_sys_reset && o_pc_undefined)
    else $error("system reset low during power-on clear");

  // Every accepted request raises the system reset on the next cycle
  reset_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    any_reset |=> o_sys_reset && o_pc_undefined)
    else $error("system reset missing after request");

  // Outside a reset the peripherals must see a frozen table
  init_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !any_reset && !o_sys_reset |=> $stable(o_init))
    else $error("initial state changed outside reset");

  // Watchdog request sets its flag, even over a read in the same cycle
  wdt_sets_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_wdt_reset && !i_pin_reset |=> o_sys_reset && wdt_flag_q)
    else $error("watchdog flag not set");

  // A detector reset sets its flag and leaves the detector enabled
  lvd_sets_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    lvd_act && !i_pin_reset && !i_wdt_reset |=> lvd_flag_q && lv_en_q)
    else $error("low-voltage flag not set or enable lost");

  // Pin reset wipes both flags and the detector control
  pin_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_pin_reset |=> !wdt_flag_q && !lvd_flag_q && !lv_en_q)
    else $error("pin reset did not clear");

  // A read returns the old byte and leaves zeros behind
  read_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    cause_rd && !any_reset |=> o_rdata == $past(cause_val) && cause_val == RCI_CAUSE_RST)
    else $error("read did not clear cause");

  // Watchdog reset leaves the low-voltage flag alone
  wdt_holds_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_wdt_reset && !i_pin_reset && !lvd_act && !cause_rd |=>
      lvd_flag_q == $past(lvd_flag_q))
    else $error("watchdog reset disturbed other flag");

  // Detector reset leaves the watchdog flag alone
  lvd_holds_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    lvd_act && !i_pin_reset && !i_wdt_reset && !cause_rd |=>
      wdt_flag_q == $past(wdt_flag_q))
    else $error("low-voltage reset disturbed other flag");

  // Unused positions of a returned cause byte stay zero
  unused_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    cause_rd |=> o_rdata_valid && (o_rdata & 8'hee) == 8'h00)
    else $error("unused cause bit set");

  // A write aimed at the cause register changes nothing
  cause_ro_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_bus.wr && cause_hit && !any_reset && !cause_rd |=> cause_val == $past(cause_val))
    else $error("write reached cause register");

  // Pin and watchdog resets switch the detector off
  lv_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_pin_reset || i_wdt_reset |=> !o_lv_enable && !o_lv_reset_mode)
    else $error("detector control survived reset");

  // The detector's own reset keeps it armed
  lv_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    lvd_act && !i_pin_reset && !i_wdt_reset |=> o_lv_enable && o_lv_reset_mode)
    else $error("detector control lost on own reset");

  // Interrupt mode follows the comparator one cycle late
  lv_irq_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    lv_en_q && !lv_md_q && i_lvd_compare |=> o_lv_irq)
    else $error("detector interrupt missing");

  // Standby seen at a reset keeps data memory held
  standby_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    any_reset && i_standby |=> o_ram_hold)
    else $error("memory hold missing after standby reset");

  // Strap is taken on the last reload edge of a reset
  flash_prog_mode_ctrl_init_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    any_reset ##1 !any_reset |=> o_init.flash_prog_mode_ctrl ==
      ($past(i_obp_mode) ? RCI_FLASH_PROG_MODE_CTRL_OBP : RCI_FLASH_PROG_MODE_CTRL_USER))
    else $error("flash mode init wrong");

  // Table values two cycles after any reset request
  mask_init_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    any_reset |=> ##1 o_init.irq_mask_high_second == RCI_MASK1H_INIT
      && o_init.async_baud_ctrl == RCI_ASYNC_BAUD_INIT)
    else $error("init table value wrong");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  // Main scenarios: each cause read back, pin wipe, irq mode, standby reset
  wdt_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    i_wdt_reset ##1 cause_rd);
  lvd_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    lvd_act ##1 cause_rd);
  pin_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    wdt_flag_q ##1 i_pin_reset);
  irq_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    lv_en_q && !lv_md_q && i_lvd_compare ##1 o_lv_irq);
  standby_cover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    any_reset && i_standby ##1 o_ram_hold);

endmodule : rci_reset_cause

/* rci_core_model.sv */
// Model of the processor core and the on-chip reset sources facing the block
// Assumes one core clock; every request changes just after a falling edge
module rci_core_model
  import rci_pkg::*;
(
  // Clock and answer
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_valid,
  // Reset requests and levels
  output logic o_pin_reset,
  output logic o_wdt_reset,
  output logic o_lvd_reset,
  output logic o_lvd_compare,
  output logic o_standby,
  output logic o_obp_mode,
  // Processor port
  output rci_pkg::rci_bus_t o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  import rci_pkg::*;

  // Quiet start; a released bus never shows the last address
  initial begin
    {o_pin_reset, o_wdt_reset, o_lvd_reset} = 3'h0;
    {o_lvd_compare, o_standby, o_obp_mode} = 3'h0;
    o_bus = '0;
  end

  // One-cycle request from one source, then all requests drop
  task automatic pulse(input rci_src_t src);
    @(negedge i_core_clk);
    o_pin_reset = (src == RCI_SRC_PIN);
    o_wdt_reset = (src == RCI_SRC_WDT);
    o_lvd_reset = (src == RCI_SRC_LVD);
    @(negedge i_core_clk);
    {o_pin_reset, o_wdt_reset, o_lvd_reset} = 3'h0;
  endtask : pulse

  // Slow levels: comparator, standby and programming strap
  task automatic levels(input logic cmp, input logic stby, input logic obp);
    @(negedge i_core_clk);
    o_lvd_compare = cmp;
    o_standby = stby;
    o_obp_mode = obp;
  endtask : levels

  // Whole-byte read; the answer is taken one edge after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge i_core_clk);
    o_bus.rd = 1'b1;
    o_bus.addr = a;
    @(negedge i_core_clk);
    d = i_rdata;
    v = i_rdata_valid;
    o_bus.rd = 1'b0;
    o_bus.addr = ~a;
  endtask : rd

  // Whole-byte write strobe of one cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_bus.wr = 1'b1;
    o_bus.addr = a;
    o_bus.wdata = d;
    @(negedge i_core_clk);
    o_bus.wr = 1'b0;
    o_bus.addr = ~a;
    o_bus.wdata = ~d;
  endtask : wr
endmodule : rci_core_model

/* reset_cause_and_init_state_test.sv */
// Self-checking bench for the reset cause recorder and initial state loader
// Assumes the core model drives all requests; the bench owns clock and reset
module reset_cause_and_init_state_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rci_pkg::*;

  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic pin_rst, wdt_rst, lvd_rst, lvd_cmp, stby, obp;
  rci_bus_t bus;
  logic [7:0] o_rdata;
  logic o_rdata_valid, o_sys_reset, o_pc_undefined, o_ram_hold;
  logic o_lv_enable, o_lv_reset_mode, o_lv_irq;
  rci_init_t o_init;
  int n_errors = 0;
  int n_checks = 0;

  // ----------------------------------------
  // Clock, instances and hang guard
  // ----------------------------------------
  initial forever #2.5 i_core_clk = ~i_core_clk;

  rci_reset_cause i_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_pin_reset(pin_rst),
    .i_wdt_reset(wdt_rst), .i_lvd_reset(lvd_rst), .i_lvd_compare(lvd_cmp), .i_standby(stby),
    .i_obp_mode(obp), .i_bus(bus), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid),
    .o_sys_reset(o_sys_reset), .o_pc_undefined(o_pc_undefined), .o_ram_hold(o_ram_hold),
    .o_lv_enable(o_lv_enable), .o_lv_reset_mode(o_lv_reset_mode), .o_lv_irq(o_lv_irq),
    .o_init(o_init));

  rci_core_model i_model (.i_core_clk(i_core_clk), .i_rdata(o_rdata),
    .i_rdata_valid(o_rdata_valid), .o_pin_reset(pin_rst), .o_wdt_reset(wdt_rst),
    .o_lvd_reset(lvd_rst), .o_lvd_compare(lvd_cmp), .o_standby(stby), .o_obp_mode(obp),
    .o_bus(bus));

  // A stuck run still ends in the verdict
  initial begin
    repeat (100000) @(posedge i_core_clk);
    n_errors++;
    summarize();
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      $display("unexpected at %0t: %s", $time, msg);
      n_errors++;
    end
  endtask : check

  // Read one register and compare the byte and its valid pulse
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input logic vexp);
    logic [7:0] d;
    logic v;
    i_model.rd(a, d, v);
    check(v, vexp, "read valid");
    if (vexp) check(d, exp, "read data");
  endtask : rdchk

  // Reset request, then sys reset for exactly one cycle
  task automatic reset_by(input rci_src_t src);
    i_model.pulse(src);
    check(o_sys_reset, 1'b1, "reset not raised");
    check(o_pc_undefined, 1'b1, "pc flag");
    @(negedge i_core_clk);
    check(o_sys_reset, 1'b0, "reset too long");
  endtask : reset_by

  // Expected initial state; undefined entries are driven 0 by choice
  function automatic rci_init_t exp_init(input logic obp_on);
    rci_init_t e;
    e = '0;
    e.async_mode = 8'h01;
    e.async_baud_ctrl = 8'h1f;
    e.async_rx_buffer = 8'hff;
    e.async_tx_shift = 8'hff;
    e.irq_priority_flags = 8'hff;
    e.irq_mask_flags = 8'hff;
    e.irq_mask_high_second = 8'hdf;
    e.flash_prog_mode_ctrl = obp_on ? 8'h0c : 8'h08;
    return e;
  endfunction : exp_init

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_after_poc;
    check(o_init, exp_init(1'b0), "init table");
    rdchk(16'hffac, 8'h00, 1'b1);
    rdchk(16'hff78, 8'h00, 1'b1);
    i_model.wr(16'hffac, 8'hff);
    rdchk(16'hffac, 8'h00, 1'b1);
    rdchk(16'hffad, 8'h00, 1'b0);
  endtask : t_after_poc

  // Watchdog then low-voltage, both flags kept by the other source
  task automatic t_flags;
    reset_by(RCI_SRC_WDT);
    i_model.levels(1'b1, 1'b0, 1'b0);
    i_model.wr(16'hff78, 8'h82);
    reset_by(RCI_SRC_LVD);
    rdchk(16'hff78, 8'h83, 1'b1);
    rdchk(16'hffac, 8'h11, 1'b1);
    rdchk(16'hffac, 8'h00, 1'b1);
    reset_by(RCI_SRC_LVD);
    reset_by(RCI_SRC_WDT);
    rdchk(16'hffac, 8'h11, 1'b1);
    rdchk(16'hff78, 8'h00, 1'b1);
    check({o_lv_enable, o_lv_reset_mode}, 2'h0, "lv bits");
  endtask : t_flags

  // Interrupt mode: comparator raises irq, detector trip is no reset
  task automatic t_lv_irq;
    i_model.wr(16'hff78, 8'h80);
    repeat (2) @(negedge i_core_clk);
    check(o_lv_irq, 1'b1, "lv irq");
    i_model.pulse(RCI_SRC_LVD);
    check(o_sys_reset, 1'b0, "lv irq mode reset");
    rdchk(16'hffac, 8'h00, 1'b1);
    i_model.levels(1'b0, 1'b0, 1'b0);
  endtask : t_lv_irq

  // Pin reset clears flags; strap and standby seen on reset
  task automatic t_pin;
    reset_by(RCI_SRC_WDT);
    i_model.levels(1'b0, 1'b1, 1'b1);
    reset_by(RCI_SRC_PIN);
    check(o_ram_hold, 1'b1, "ram hold");
    check(o_init, exp_init(1'b1), "init obp");
    rdchk(16'hffac, 8'h00, 1'b1);
    i_model.levels(1'b0, 1'b0, 1'b0);
  endtask : t_pin

  // Power-on clear in mid-run
  task automatic t_poc;
    reset_by(RCI_SRC_WDT);
    @(negedge i_core_clk);
    i_rst_b = 1'b0;
    repeat (3) @(negedge i_core_clk);
    check(o_sys_reset, 1'b1, "poc reset");
    i_rst_b = 1'b1;
    @(negedge i_core_clk);
    check(o_init, exp_init(1'b0), "init after poc");
    rdchk(16'hffac, 8'h00, 1'b1);
  endtask : t_poc

  task automatic summarize;
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (20) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    @(negedge i_core_clk);
    t_after_poc();
    t_flags();
    t_lv_irq();
    t_pin();
    t_poc();
    summarize();
  end
endmodule : reset_cause_and_init_state_test
